/* File: logic/gsc_ratio_div.sv */
// Purpose: sequential restoring divider for the charge percentage
// Assumes: a new division may start whenever busy is low
// Notes: divide by zero returns an all-ones quotient
`timescale 1ns/10ps
`default_nettype none
module gsc_ratio_div #(
	parameter int NW = 24,
	parameter int DW = 16
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic start,
	input wire logic [NW-1:0] numer,
	input wire logic [DW-1:0] denom,
	output logic busy,
	output logic done,
	output logic [NW-1:0] quot
);
	import gsc_pkg::*;

	gsc_div_state_t state_r;
	logic [NW-1:0] num_r;
	logic [NW-1:0] q_r;
	logic [DW:0] rem_r;
	logic [DW-1:0] den_r;
	logic [$clog2(NW+1)-1:0] cnt_r;
	logic [DW:0] trial;

	// shifted remainder for the current step
	assign trial = {rem_r[DW-1:0], num_r[NW-1]};
	assign busy = (state_r == DIV_RUN);

	// one quotient bit per clock
	always_ff @(posedge clock) begin
		if (rst) begin
			state_r <= DIV_IDLE;
			num_r <= '0;
			q_r <= '0;
			rem_r <= '0;
			den_r <= '0;
			cnt_r <= '0;
			quot <= '0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state_r)
				DIV_IDLE: begin
					if (start) begin
						num_r <= numer;
						den_r <= denom;
						rem_r <= '0;
						q_r <= '0;
						cnt_r <= NW[$clog2(NW+1)-1:0];
						state_r <= DIV_RUN;
					end
				end
				DIV_RUN: begin
					num_r <= {num_r[NW-2:0], 1'b0};
					if (trial >= {1'b0, den_r}) begin
						rem_r <= trial - {1'b0, den_r};
						q_r <= {q_r[NW-2:0], 1'b1};
					end else begin
						rem_r <= trial;
						q_r <= {q_r[NW-2:0], 1'b0};
					end
					cnt_r <= cnt_r - 1'b1;
					if (cnt_r == 1) begin
						state_r <= DIV_IDLE;
						done <= 1'b1;
						quot <= (trial >= {1'b0, den_r}) ? {q_r[NW-2:0], 1'b1} :
							{q_r[NW-2:0], 1'b0};
					end
				end
				default: state_r <= DIV_IDLE;
			endcase
		end
	end
endmodule : gsc_ratio_div
`default_nettype wire

/* File: logic/gsc_status_regs.sv */
// Purpose: read-only voltage, status flag, charge percent and capacity registers
// Assumes: measurement and event inputs synchronous to clock; serial link outside
// Notes: rst is the gauge reset; reset_full and ram_corrupt qualify it
`timescale 1ns/10ps
`default_nettype none
module gsc_status_regs #(
	parameter longint UPDATE_CYCLES = gsc_pkg::VOLT_UPDATE_CYCLES,
	parameter logic [15:0] LMD_DESIGN = 16'h1000
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic reset_full,
	input wire logic ram_corrupt,
	input wire logic [15:0] meas_voltage_mv,
	input wire logic charge_current,
	input wire logic discharge_current,
	input wire logic below_dmf,
	input wire logic taper_current_flag,
	input wire logic cal_measuring,
	input wire logic learn_conditions_met,
	input wire logic learn_disqualify,
	input wire logic [15:0] first_end_discharge_flag_threshold_mv,
	input wire logic [15:0] final_end_discharge_flag_threshold_mv,
	input wire logic empty_reached,
	input wire logic cap_unit_pulse,
	input wire logic cycle_count_inc,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	output logic [7:0] reg_rd_data,
	output logic [15:0] last_measured_discharge
);
	import gsc_pkg::*;

	localparam int UCW = $clog2(UPDATE_CYCLES + 1);
	localparam int NW = 24;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// saturating 16-bit step up or down
	function automatic logic [15:0] sat_step(input logic [15:0] v, input logic up);
		logic [15:0] r;
		r = v;
		if (up && v != NAC_MAX)
			r = v + 16'h0001;
		else if (!up && v != NAC_RESET)
			r = v - 16'h0001;
		return r;
	endfunction : sat_step

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [UCW-1:0] upd_cnt_r;
	logic [15:0] volt_r;
	logic [15:0] nominal_available_capacity;
	logic [15:0] learn_count_r;
	logic [5:0] since_learn_r;
	logic charge_active_flag;
	logic idle_current_flag;
	logic learned_capacity_stale;
	logic offset_cal_running;
	logic learning_qualified_flag;
	logic first_end_discharge_flag;
	logic final_end_discharge_flag;
	logic [7:0] relative_charge_percent;
	logic [7:0] hi_shadow_r;
	logic first_end_discharge_flag_cond;
	logic lmd_update;
	logic [7:0] flags_byte;
	logic div_busy;
	logic div_done;
	logic [NW-1:0] div_quot;
	logic [NW-1:0] div_numer;

	// ----------------------------------------------------------------
	// voltage refresh
	// ----------------------------------------------------------------
	// period counter for the voltage refresh
	always_ff @(posedge clock) begin
		if (rst || upd_cnt_r == UCW'(UPDATE_CYCLES - 1))
			upd_cnt_r <= '0;
		else
			upd_cnt_r <= upd_cnt_r + 1'b1;
	end

	// sample and clip the measured voltage
	always_ff @(posedge clock) begin
		if (rst)
			volt_r <= VOLT_RESET_MV;
		else if (upd_cnt_r == UCW'(UPDATE_CYCLES - 1)) begin
			if (meas_voltage_mv > VOLT_MAX_MV)
				volt_r <= VOLT_MAX_MV;
			else
				volt_r <= meas_voltage_mv;
		end
	end

	// ----------------------------------------------------------------
	// live status flags
	// ----------------------------------------------------------------
	assign first_end_discharge_flag_cond = (volt_r <= first_end_discharge_flag_threshold_mv) &&
		({nominal_available_capacity, 4'h0} <= {4'h0, last_measured_discharge});
	assign lmd_update = first_end_discharge_flag_cond && !first_end_discharge_flag && learning_qualified_flag;

	// flags that follow conditions, all cleared by any reset
	always_ff @(posedge clock) begin
		if (rst) begin
			charge_active_flag <= 1'b0;
			idle_current_flag <= 1'b0;
			offset_cal_running <= 1'b0;
			first_end_discharge_flag <= 1'b0;
			final_end_discharge_flag <= 1'b0;
		end else begin
			charge_active_flag <= charge_current;
			idle_current_flag <= below_dmf;
			offset_cal_running <= cal_measuring;
			first_end_discharge_flag <= first_end_discharge_flag_cond;
			final_end_discharge_flag <= empty_reached;
		end
	end

	// learning qualification, cleared by update or disqualification
	always_ff @(posedge clock) begin
		if (rst)
			learning_qualified_flag <= 1'b0;
		else if (lmd_update || learn_disqualify)
			learning_qualified_flag <= 1'b0;
		else if (learn_conditions_met)
			learning_qualified_flag <= 1'b1;
	end

	// ----------------------------------------------------------------
	// learned capacity and its staleness
	// ----------------------------------------------------------------
	// discharge counted during a qualified cycle
	always_ff @(posedge clock) begin
		if (rst || !learning_qualified_flag)
			learn_count_r <= NAC_RESET;
		else if (cap_unit_pulse && discharge_current)
			learn_count_r <= sat_step(learn_count_r, 1'b1);
	end

	// learned capacity, kept across resets unless state is lost
	always_ff @(posedge clock) begin
		if (rst) begin
			if (reset_full || ram_corrupt)
				last_measured_discharge <= LMD_DESIGN;
		end else if (lmd_update)
			last_measured_discharge <= learn_count_r;
	end

	// cycle increments since the last learning cycle
	always_ff @(posedge clock) begin
		if (rst) begin
			if (reset_full || ram_corrupt)
				since_learn_r <= '0;
		end else if (lmd_update)
			since_learn_r <= '0;
		else if (cycle_count_inc && since_learn_r != STALE_CYCLE_LIMIT)
			since_learn_r <= since_learn_r + 6'h01;
	end

	// capacity stale flag
	always_ff @(posedge clock) begin
		if (rst) begin
			if (reset_full || ram_corrupt)
				learned_capacity_stale <= 1'b1;
		end else if (cycle_count_inc && since_learn_r == STALE_CYCLE_LIMIT - 6'h01)
			learned_capacity_stale <= 1'b1;
		else if (lmd_update)
			learned_capacity_stale <= 1'b0;
	end

	// ----------------------------------------------------------------
	// nominal available capacity
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			if (ram_corrupt)
				nominal_available_capacity <= NAC_RESET;
		end else if (cap_unit_pulse) begin
			if (charge_current && volt_r > final_end_discharge_flag_threshold_mv)
				nominal_available_capacity <= sat_step(nominal_available_capacity, 1'b1);
			else if (discharge_current)
				nominal_available_capacity <= sat_step(nominal_available_capacity, 1'b0);
		end
	end

	// ----------------------------------------------------------------
	// relative charge percent
	// ----------------------------------------------------------------
	assign div_numer = NW'(nominal_available_capacity) * NW'(RELATIVE_CHARGE_PERCENT_SCALE);

	gsc_ratio_div #(
		.NW(NW),
		.DW(16)
	) u_div (
		.clock(clock),
		.rst(rst),
		.start(!div_busy),
		.numer(div_numer),
		.denom(last_measured_discharge),
		.busy(div_busy),
		.done(div_done),
		.quot(div_quot)
	);

	// clip the quotient to one hundred percent
	always_ff @(posedge clock) begin
		if (rst)
			relative_charge_percent <= 8'h00;
		else if (div_done) begin
			if (div_quot > NW'(RELATIVE_CHARGE_PERCENT_SCALE))
				relative_charge_percent <= RELATIVE_CHARGE_PERCENT_SCALE;
			else
				relative_charge_percent <= div_quot[7:0];
		end
	end

	// ----------------------------------------------------------------
	// register read port
	// ----------------------------------------------------------------
	always_comb begin
		flags_byte = 8'h00;
		flags_byte[BIT_CHG] = charge_active_flag;
		flags_byte[BIT_IDLE] = idle_current_flag;
		flags_byte[BIT_TAPER] = taper_current_flag;
		flags_byte[BIT_STALE] = learned_capacity_stale;
		flags_byte[BIT_CAL] = offset_cal_running;
		flags_byte[BIT_QUAL] = learning_qualified_flag;
		flags_byte[BIT_FIRST_END_DISCHARGE_FLAG] = first_end_discharge_flag;
		flags_byte[BIT_FINAL_END_DISCHARGE_FLAG] = final_end_discharge_flag;
	end

	// high byte captured when its low byte is read
	always_ff @(posedge clock) begin
		if (rst)
			hi_shadow_r <= 8'h00;
		else if (reg_rd_en && reg_addr == OFS_VOLT_LO)
			hi_shadow_r <= volt_r[15:8];
		else if (reg_rd_en && reg_addr == OFS_NAC_LO)
			hi_shadow_r <= nominal_available_capacity[15:8];
	end

	// read data, one cycle after the strobe; no write path exists
	always_ff @(posedge clock) begin
		if (rst)
			reg_rd_data <= RD_UNMAPPED;
		else if (reg_rd_en) begin
			if (reg_addr == OFS_VOLT_LO)
				reg_rd_data <= volt_r[7:0];
			else if (reg_addr == OFS_VOLT_HI)
				reg_rd_data <= hi_shadow_r;
			else if (reg_addr == OFS_FLAGS)
				reg_rd_data <= flags_byte;
			else if (reg_addr == OFS_RELATIVE_CHARGE_PERCENT)
				reg_rd_data <= relative_charge_percent;
			else if (reg_addr == OFS_NAC_LO)
				reg_rd_data <= nominal_available_capacity[7:0];
			else if (reg_addr == OFS_NAC_HI)
				reg_rd_data <= hi_shadow_r;
			else
				reg_rd_data <= RD_UNMAPPED;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_VOLT_CEIL: assert property (@(posedge clock) disable iff (rst)
		volt_r <= VOLT_MAX_MV)
		else $error("reported voltage above ceiling");

	AST_VOLT_HOLD: assert property (@(posedge clock) disable iff (rst)
		(upd_cnt_r != UCW'(UPDATE_CYCLES - 1)) |=> $stable(volt_r))
		else $error("voltage changed between refreshes");

	AST_CHG_FOLLOW: assert property (@(posedge clock) disable iff (rst)
		charge_current |=> charge_active_flag)
		else $error("charge flag not set during charge");

	AST_IDLE_FOLLOW: assert property (@(posedge clock) disable iff (rst)
		!below_dmf |=> !idle_current_flag)
		else $error("idle flag set above filter");

	AST_RESET_CLEAR: assert property (@(posedge clock)
		rst |=> flags_byte[BIT_CHG] == 1'b0 && !learning_qualified_flag && !offset_cal_running)
		else $error("volatile flag survived reset");

	AST_STALE_FULL: assert property (@(posedge clock)
		rst && reset_full |=> learned_capacity_stale)
		else $error("stale flag clear after full reset");

	AST_STALE_CLEAR: assert property (@(posedge clock) disable iff (rst)
		$fell(learned_capacity_stale) |-> $past(lmd_update))
		else $error("stale flag cleared without learning update");

	AST_LMD_LEARN: assert property (@(posedge clock) disable iff (rst)
		lmd_update |=> last_measured_discharge == $past(learn_count_r) && !learning_qualified_flag)
		else $error("learned capacity not updated on end of discharge");

	AST_NAC_CORRUPT: assert property (@(posedge clock)
		rst && ram_corrupt |=> nominal_available_capacity == NAC_RESET)
		else $error("capacity kept after corrupt reset");

	AST_RELATIVE_CHARGE_PERCENT_RANGE: assert property (@(posedge clock) disable iff (rst)
		relative_charge_percent <= RELATIVE_CHARGE_PERCENT_SCALE)
		else $error("charge percent above one hundred");

	AST_PAIR_ATOMIC: assert property (@(posedge clock) disable iff (rst)
		reg_rd_en && reg_addr == OFS_NAC_LO ##1 (reg_rd_en && reg_addr == OFS_NAC_HI)
		|=> reg_rd_data == $past(nominal_available_capacity[15:8], 2))
		else $error("capacity halves from different updates");
endmodule : gsc_status_regs
`default_nettype wire

/* File: shared/gsc_pkg.sv */
// Purpose: constants for the gauge status and capacity register bank
// Assumes: 250 MHz core clock, byte-wide register read port
// Notes: offsets are byte addresses of the gauge register space
package gsc_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_VOLT_LO = 8'h08;
	localparam logic [7:0] OFS_VOLT_HI = 8'h09;
	localparam logic [7:0] OFS_FLAGS = 8'h0a;
	localparam logic [7:0] OFS_RELATIVE_CHARGE_PERCENT = 8'h0b;
	localparam logic [7:0] OFS_NAC_LO = 8'h0c;
	localparam logic [7:0] OFS_NAC_HI = 8'h0d;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	// ----------------------------------------------------------------
	// status flag bit positions
	// ----------------------------------------------------------------
	localparam int BIT_CHG = 7;
	localparam int BIT_IDLE = 6;
	localparam int BIT_TAPER = 5;
	localparam int BIT_STALE = 4;
	localparam int BIT_CAL = 3;
	localparam int BIT_QUAL = 2;
	localparam int BIT_FIRST_END_DISCHARGE_FLAG = 1;
	localparam int BIT_FINAL_END_DISCHARGE_FLAG = 0;
	// ----------------------------------------------------------------
	// scaling and limits
	// ----------------------------------------------------------------
	localparam logic [15:0] VOLT_MAX_MV = 16'h1388; // 5000 mV ceiling
	localparam logic [15:0] VOLT_RESET_MV = 16'h0000;
	localparam logic [7:0] RELATIVE_CHARGE_PERCENT_SCALE = 8'h64; // 100 percent
	localparam logic [5:0] STALE_CYCLE_LIMIT = 6'h20; // 32 increments
	localparam int FIRST_END_DISCHARGE_FLAG_FRAC_SHIFT = 4; // 1/16 = 6.25 %
	localparam logic [15:0] NAC_RESET = 16'h0000;
	localparam logic [15:0] NAC_MAX = 16'hffff;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam longint CLOCK_HZ = 250000000;
	localparam longint VOLT_UPDATE_MS = 2560; // 2.56 s refresh
	localparam longint VOLT_UPDATE_CYCLES = VOLT_UPDATE_MS * CLOCK_HZ / 1000;
	// divider sequencer
	typedef enum logic [0:0] {DIV_IDLE, DIV_RUN} gsc_div_state_t;
endpackage : gsc_pkg

/* File: tb/gsc_host_model.sv */
// Purpose: host processor model that reads the gauge registers
// Assumes: one-cycle read strobe, data registered on the taking edge and read just after it
// Notes: word reads go low byte first so the pair stays coherent
`timescale 1ns/10ps
`default_nettype none
module gsc_host_model (
	input wire logic clock,
	output logic reg_rd_en,
	output logic [7:0] reg_addr,
	input wire logic [7:0] reg_rd_data
);
	// ------------------------------------------------------------
	// read tasks
	// ------------------------------------------------------------
	// idle strobe from time zero
	initial begin
		reg_rd_en = 1'b0;
		reg_addr = 8'h00;
	end
	// one strobe, data taken once the answer edge has landed
	task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd_en <= 1'b0;
		#1 d = reg_rd_data;
	endtask : read_byte
	// low byte then high byte on back-to-back strobes, high from the captured copy
	task automatic read_word(input logic [7:0] a, output logic [15:0] w);
		@(posedge clock);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_addr <= a + 8'h01;
		#1 w[7:0] = reg_rd_data;
		@(posedge clock);
		reg_rd_en <= 1'b0;
		#1 w[15:8] = reg_rd_data;
	endtask : read_word
	// sign of the unsigned current magnitude from the charge flag
	task automatic read_charge_sign(output logic s);
		logic [7:0] f;
		read_byte(gsc_pkg::OFS_FLAGS, f);
		s = f[gsc_pkg::BIT_CHG];
	endtask : read_charge_sign
endmodule : gsc_host_model
`default_nettype wire

/* File: tb/gsc_status_regs_test.sv */
// Purpose: self-checking bench for the gauge status and capacity registers
// Assumes: short refresh period, small initial learned capacity
// Notes: tests run in order and lean on the state left by the previous one
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin \
	checks_done++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
	end \
end
module gsc_status_regs_test;
	import gsc_pkg::*;
	localparam logic [15:0] LMD0 = 16'h0040;
	logic clock = 1'b0;
	logic rst, reset_full, ram_corrupt, charge_current, discharge_current, below_dmf;
	logic taper_current_flag, cal_measuring, learn_conditions_met, learn_disqualify;
	logic empty_reached, cap_unit_pulse, cycle_count_inc, reg_rd_en, s;
	logic [15:0] meas_voltage_mv, first_end_discharge_flag_threshold_mv, final_end_discharge_flag_threshold_mv, last_measured_discharge;
	logic [15:0] w;
	logic [7:0] reg_addr, reg_rd_data, d;
	logic [4:0] v;
	int num_errors = 0;
	int checks_done = 0;
	// ------------------------------------------------------------
	// design and host
	// ------------------------------------------------------------
	gsc_status_regs #(.UPDATE_CYCLES(16), .LMD_DESIGN(LMD0)) i_dut (
		.clock(clock), .rst(rst), .reset_full(reset_full), .ram_corrupt(ram_corrupt),
		.meas_voltage_mv(meas_voltage_mv), .charge_current(charge_current),
		.discharge_current(discharge_current), .below_dmf(below_dmf),
		.taper_current_flag(taper_current_flag), .cal_measuring(cal_measuring),
		.learn_conditions_met(learn_conditions_met), .learn_disqualify(learn_disqualify),
		.first_end_discharge_flag_threshold_mv(first_end_discharge_flag_threshold_mv), .final_end_discharge_flag_threshold_mv(final_end_discharge_flag_threshold_mv),
		.empty_reached(empty_reached), .cap_unit_pulse(cap_unit_pulse),
		.cycle_count_inc(cycle_count_inc), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
		.reg_rd_data(reg_rd_data), .last_measured_discharge(last_measured_discharge)
	);
	gsc_host_model i_host (
		.clock(clock), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_rd_data(reg_rd_data)
	);
	// free-running clock
	always #2 clock = ~clock;
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	// spaced one-cycle pulses: 0 capacity count, 1 cycle count, 2 learn, 3 disqualify
	task automatic pulses(input int which, input int n);
		repeat (n) begin
			@(posedge clock);
			case (which)
				0: cap_unit_pulse <= 1'b1;
				1: cycle_count_inc <= 1'b1;
				2: learn_conditions_met <= 1'b1;
				default: learn_disqualify <= 1'b1;
			endcase
			@(posedge clock);
			{cap_unit_pulse, cycle_count_inc, learn_conditions_met, learn_disqualify} <= 4'h0;
		end
		tick(3);
	endtask : pulses
	task automatic do_reset(input logic full, input logic corrupt);
		@(posedge clock);
		{rst, reset_full, ram_corrupt} <= {1'b1, full, corrupt};
		tick(8);
		{rst, reset_full, ram_corrupt} <= 3'b000;
		tick(2);
	endtask : do_reset
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset_values();
		logic [7:0] unm[3] = '{8'h07, 8'h0e, 8'hff};
		// voltage reads zero until the first refresh and capacity is empty, so bit 1 rises
		i_host.read_byte(OFS_FLAGS, d);
		`CHK(d, 8'h12)
		i_host.read_word(OFS_NAC_LO, w);
		`CHK(w, NAC_RESET)
		`CHK(last_measured_discharge, LMD0)
		// nonzero flags read first so a held data byte cannot pass
		foreach (unm[i]) begin
			i_host.read_byte(OFS_FLAGS, d);
			i_host.read_byte(unm[i], d);
			`CHK(d, RD_UNMAPPED)
		end
		$display("test reset_values done");
	endtask : t_reset_values
	task automatic t_voltage();
		logic [15:0] vin[4] = '{16'h0e74, 16'h1387, 16'h1388, 16'h1770};
		logic [15:0] vex[4] = '{16'h0e74, 16'h1387, 16'h1388, VOLT_MAX_MV};
		foreach (vin[i]) begin
			@(posedge clock);
			meas_voltage_mv <= vin[i];
			tick(40);
			i_host.read_word(OFS_VOLT_LO, w);
			`CHK(w, vex[i])
		end
		@(posedge clock);
		meas_voltage_mv <= 16'h0e74;
		tick(40);
		i_host.read_byte(OFS_VOLT_LO, d);
		`CHK(d, 8'h74)
		@(posedge clock);
		meas_voltage_mv <= 16'h0102;
		tick(40);
		i_host.read_byte(OFS_VOLT_HI, d);
		`CHK(d, 8'h0e)
		i_host.read_word(OFS_VOLT_LO, w);
		`CHK(w, 16'h0102)
		$display("test voltage done");
	endtask : t_voltage
	task automatic t_flags();
		for (int i = 0; i < 7; i++) begin
			v = (i < 5) ? (5'h01 << i) : ((i == 5) ? 5'h1f : 5'h00);
			@(posedge clock);
			{charge_current, below_dmf, taper_current_flag, cal_measuring, empty_reached} <= v;
			tick(3);
			i_host.read_byte(OFS_FLAGS, d);
			`CHK(d, {v[4], v[3], v[2], 1'b1, v[1], 2'b00, v[0]})
			if (i == 4) begin
				i_host.read_charge_sign(s);
				`CHK(s, 1'b1)
			end
		end
		$display("test flags done");
	endtask : t_flags
	task automatic t_capacity();
		@(posedge clock);
		charge_current <= 1'b1;
		pulses(0, 20);
		i_host.read_word(OFS_NAC_LO, w);
		`CHK(w, 16'h0014)
		@(posedge clock);
		final_end_discharge_flag_threshold_mv <= 16'h1000;
		pulses(0, 3);
		i_host.read_word(OFS_NAC_LO, w);
		`CHK(w, 16'h0014)
		@(posedge clock);
		{final_end_discharge_flag_threshold_mv, charge_current, discharge_current} <= {16'h0010, 2'b01};
		pulses(0, 4);
		i_host.read_word(OFS_NAC_LO, w);
		`CHK(w, 16'h0010)
		tick(60);
		i_host.read_byte(OFS_RELATIVE_CHARGE_PERCENT, d);
		`CHK(d, 8'h19)
		$display("test capacity done");
	endtask : t_capacity
	task automatic t_learning();
		pulses(2, 1);
		i_host.read_byte(OFS_FLAGS, d);
		`CHK(d, 8'h14)
		@(posedge clock);
		first_end_discharge_flag_threshold_mv <= 16'h0200;
		pulses(0, 12);
		tick(3);
		`CHK(last_measured_discharge, 16'h000c)
		i_host.read_byte(OFS_FLAGS, d);
		`CHK(d & 8'h14, 8'h00)
		@(posedge clock);
		{first_end_discharge_flag_threshold_mv, discharge_current} <= {16'h0000, 1'b0};
		pulses(2, 1);
		i_host.read_byte(OFS_FLAGS, d);
		`CHK(d, 8'h04)
		pulses(3, 1);
		i_host.read_byte(OFS_FLAGS, d);
		`CHK(d, 8'h00)
		$display("test learning done");
	endtask : t_learning
	task automatic t_later_resets();
		do_reset(1'b0, 1'b0);
		i_host.read_byte(OFS_FLAGS, d);
		`CHK(d, 8'h00)
		i_host.read_word(OFS_NAC_LO, w);
		`CHK(w, 16'h0004)
		`CHK(last_measured_discharge, 16'h000c)
		pulses(1, 31);
		i_host.read_byte(OFS_FLAGS, d);
		`CHK(d, 8'h00)
		pulses(1, 1);
		i_host.read_byte(OFS_FLAGS, d);
		`CHK(d, 8'h10)
		do_reset(1'b0, 1'b1);
		i_host.read_word(OFS_NAC_LO, w);
		`CHK(w, NAC_RESET)
		// empty capacity at zero reported voltage raises bit 1 until the refresh
		i_host.read_byte(OFS_FLAGS, d);
		`CHK(d, 8'h12)
		`CHK(last_measured_discharge, LMD0)
		$display("test later_resets done");
	endtask : t_later_resets
	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		{rst, reset_full, ram_corrupt} = 3'b111;
		{charge_current, discharge_current, below_dmf, taper_current_flag} = 4'h0;
		{cal_measuring, learn_conditions_met, learn_disqualify, empty_reached} = 4'h0;
		{cap_unit_pulse, cycle_count_inc} = 2'b00;
		{meas_voltage_mv, first_end_discharge_flag_threshold_mv, final_end_discharge_flag_threshold_mv} = {32'h0, 16'h0010};
		tick(8);
		{rst, reset_full, ram_corrupt} <= 3'b000;
		tick(2);
		t_reset_values();
		t_voltage();
		t_flags();
		t_capacity();
		t_learning();
		t_later_resets();
		report_and_stop();
	end
	initial begin
		tick(20000);
		num_errors++;
		report_and_stop();
	end
endmodule : gsc_status_regs_test
`undef CHK
`default_nettype wire
